// File: pipe_ctrl_defs.svh
// timing and field constants for the pipeline control block
`ifndef PIPE_CTRL_DEFS_SVH
`define PIPE_CTRL_DEFS_SVH
`define STAGE_COUNT 5
`define ALIAS_REG_NUM 4'hf
`define REG_W 4
`define PC_W 32
`define PC_STEP 32'h0000_0002
`define RESET_PC 32'h0000_0000
`define STACK_SEL_RESET 1'h0
`define TAKEN_BRANCH_CYCLES 2
`define DELAYED_BRANCH_CYCLES 1
`endif

// File: pipe_ctrl_pkg.sv
// types for the pipeline control block
package pipe_ctrl_pkg;
    typedef enum logic [1:0] {
        br_none = 2'b00,
        br_plain = 2'b01,
        br_delayed = 2'b10
    } branch_kind_e;
endpackage

// File: delayed_branch_pipeline_control.sv
// pipeline control: stack-select interlock, load interlock, branch cancel and delay slot
// Summary of operation
// - five stages fetch, decode, alu, memory, writeback; one instruction per cycle
// - hold decode when it needs a register a load in alu stage still owes
// - stack alias register maps to system or user stack pointer by stack-select flag
// - stall one cycle when flag change is followed by stack alias reference
// - stall one cycle when flag change is followed by two-register format
// - taken plain branch cancels the fetched follower, then fetches the target
// - taken plain branch costs two cycles, untaken costs one
// - untaken plain branch lets the follower complete, continuing in sequence
// - delayed branch always completes its delay-slot instruction
// - delayed branch costs one cycle whether taken or not
// - taken delayed branch runs the slot instruction before the target
// - no exception, interrupt or trap accepted during delayed branch or its slot
`timescale 1ns/1ps
`include "pipe_ctrl_defs.svh"

module delayed_branch_pipeline_control #(
    parameter int PC_W = `PC_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // decode-stage instruction attributes
    input wire logic dec_valid,
    input wire logic [`REG_W-1:0] dec_src_a,
    input wire logic [`REG_W-1:0] dec_src_b,
    input wire logic dec_uses_src_a,
    input wire logic dec_uses_src_b,
    input wire logic dec_two_reg_format,
    input wire logic dec_writes_stack_sel,
    input wire logic dec_is_load,
    input wire logic [`REG_W-1:0] dec_dest,
    input wire pipe_ctrl_pkg::branch_kind_e dec_branch,
    input wire logic [PC_W-1:0] dec_target,
    // branch resolution and flag update from alu stage
    input wire logic alu_branch_cond,
    input wire logic alu_new_stack_sel,
    // pending exception_trap_processing request
    input wire logic exception_trap_request,
    // fetch control
    output logic [PC_W-1:0] fetch_pc,
    output logic fetch_hold,
    // stage valid bits, decode_stage to register_writeback_stage
    output logic decode_stage_valid,
    output logic alu_stage_valid,
    output logic memory_access_stage_valid,
    output logic register_writeback_stage_valid,
    // hazards, cancellation and status
    output logic decode_stall,
    output logic cancel_follower,
    output logic stack_sel,
    output logic alias_uses_user_sp,
    output logic exception_trap_accept
);
    // pipeline state
    logic [PC_W-1:0] pc;
    logic ex_v, ma_v, wb_v;
    logic ex_load, ex_sflag;
    logic [`REG_W-1:0] ex_dest;
    pipe_ctrl_pkg::branch_kind_e ex_br;
    logic slot_pending;
    logic sflag;
    logic stall_q, cancel_q, accept_q;
    logic [PC_W-1:0] next_pc;
    logic next_ex_v, next_ma_v, next_wb_v, next_ex_load, next_ex_sflag;
    logic [`REG_W-1:0] next_ex_dest;
    pipe_ctrl_pkg::branch_kind_e next_ex_br;
    logic next_slot_pending, next_sflag, next_stall, next_cancel, next_accept;
    logic load_hz, stack_hz, stall, taken_plain, taken_delayed, dec_live;

    function automatic logic reads_reg(input logic [`REG_W-1:0] r);
        reads_reg = (dec_uses_src_a && dec_src_a == r) || (dec_uses_src_b && dec_src_b == r);
    endfunction

    always_comb begin
        dec_live = dec_valid && !cancel_q;
        load_hz = dec_live && ex_v && ex_load && reads_reg(ex_dest);
        stack_hz = dec_live && ex_v && ex_sflag
            && (reads_reg(`ALIAS_REG_NUM) || dec_two_reg_format);
        stall = load_hz || stack_hz;
        // branches resolve in decode, so only one fetched follower is ever in flight
        taken_plain = dec_live && !stall && dec_branch == pipe_ctrl_pkg::br_plain
            && alu_branch_cond;
        taken_delayed = dec_live && !stall && dec_branch == pipe_ctrl_pkg::br_delayed
            && alu_branch_cond;
        // the follower is in fetch now; it is squashed as it reaches decode next cycle
        next_cancel = taken_plain;
        next_stall = stall;
        next_pc = (taken_plain || taken_delayed) ? dec_target
            : (stall ? pc : PC_W'(pc + `PC_STEP));
        next_ex_v = dec_live && !stall;
        next_ex_load = dec_is_load;
        next_ex_sflag = dec_writes_stack_sel;
        next_ex_dest = dec_dest;
        next_ex_br = dec_branch;
        next_ma_v = ex_v;
        next_wb_v = ma_v;
        next_sflag = (ex_v && ex_sflag) ? alu_new_stack_sel : sflag;
        // slot runs while the delayed branch is in alu stage; stays pending until it advances
        next_slot_pending = ex_v && ex_br == pipe_ctrl_pkg::br_delayed;
        next_accept = exception_trap_request && !next_slot_pending && !slot_pending
            && !(dec_live && dec_branch == pipe_ctrl_pkg::br_delayed);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc <= PC_W'(`RESET_PC);
            ex_v <= 1'b0;
            ma_v <= 1'b0;
            wb_v <= 1'b0;
            ex_load <= 1'b0;
            ex_sflag <= 1'b0;
            ex_dest <= '0;
            ex_br <= pipe_ctrl_pkg::br_none;
            slot_pending <= 1'b0;
            sflag <= `STACK_SEL_RESET;
            stall_q <= 1'b0;
            cancel_q <= 1'b0;
            accept_q <= 1'b0;
        end else begin
            pc <= next_pc;
            ex_v <= next_ex_v;
            ma_v <= next_ma_v;
            wb_v <= next_wb_v;
            ex_load <= next_ex_load;
            ex_sflag <= next_ex_sflag;
            ex_dest <= next_ex_dest;
            ex_br <= next_ex_br;
            slot_pending <= next_slot_pending;
            sflag <= next_sflag;
            stall_q <= next_stall;
            cancel_q <= next_cancel;
            accept_q <= next_accept;
        end
    end

    // outputs straight from flip-flops
    logic dec_v_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dec_v_q <= 1'b0;
        end else begin
            dec_v_q <= dec_live;
        end
    end

    assign fetch_pc = pc;
    assign fetch_hold = stall_q;
    assign decode_stage_valid = dec_v_q;
    assign alu_stage_valid = ex_v;
    assign memory_access_stage_valid = ma_v;
    assign register_writeback_stage_valid = wb_v;
    assign decode_stall = stall_q;
    assign cancel_follower = cancel_q;
    assign stack_sel = sflag;
    assign alias_uses_user_sp = sflag;
    assign exception_trap_accept = accept_q;

    property p_sflag_interlock;
        @(posedge clk) disable iff (!resetn)
        (dec_valid && !cancel_q && ex_v && ex_sflag && dec_two_reg_format) |=> decode_stall;
    endproperty
    a_sflag_interlock: assert property (p_sflag_interlock) else $error("no stall after flag change");

    property p_alias_stall;
        @(posedge clk) disable iff (!resetn)
        (dec_valid && !cancel_q && ex_v && ex_sflag && dec_uses_src_a
            && dec_src_a == `ALIAS_REG_NUM) |=> decode_stall ##1 1'b1;
    endproperty
    a_alias_stall: assert property (p_alias_stall) else $error("alias reference not stalled");

    property p_load_stall;
        @(posedge clk) disable iff (!resetn)
        load_hz |=> decode_stall && !alu_stage_valid && fetch_pc == $past(fetch_pc);
    endproperty
    a_load_stall: assert property (p_load_stall) else $error("load hazard not held");

    property p_plain_cancel;
        @(posedge clk) disable iff (!resetn)
        taken_plain |=> cancel_follower && fetch_pc == $past(dec_target) ##1 !alu_stage_valid;
    endproperty
    a_plain_cancel: assert property (p_plain_cancel) else $error("follower not cancelled");

    property p_untaken_plain;
        @(posedge clk) disable iff (!resetn)
        (dec_live && !stall && dec_branch == pipe_ctrl_pkg::br_plain && !alu_branch_cond)
            |=> !cancel_follower;
    endproperty
    a_untaken_plain: assert property (p_untaken_plain) else $error("untaken branch cancelled");

    property p_delay_slot;
        @(posedge clk) disable iff (!resetn)
        (ex_v && ex_br == pipe_ctrl_pkg::br_delayed && dec_valid && !cancel_q && !stall)
            |=> alu_stage_valid && !cancel_follower;
    endproperty
    a_delay_slot: assert property (p_delay_slot) else $error("delay slot lost");

    property p_delayed_target;
        @(posedge clk) disable iff (!resetn)
        taken_delayed |=> fetch_pc == $past(dec_target);
    endproperty
    a_delayed_target: assert property (p_delayed_target) else $error("target not fetched");

    property p_delayed_cost;
        @(posedge clk) disable iff (!resetn)
        taken_delayed |=> !cancel_follower ##1 !cancel_follower;
    endproperty
    a_delayed_cost: assert property (p_delayed_cost) else $error("delayed branch lost a cycle");

    property p_no_accept;
        @(posedge clk) disable iff (!resetn)
        (ex_v && ex_br == pipe_ctrl_pkg::br_delayed) |=> !exception_trap_accept [*2];
    endproperty
    a_no_accept: assert property (p_no_accept) else $error("trap accepted in delay slot");

    property p_stage_flow;
        @(posedge clk) disable iff (!resetn)
        alu_stage_valid |=> memory_access_stage_valid ##1 register_writeback_stage_valid;
    endproperty
    a_stage_flow: assert property (p_stage_flow) else $error("stage did not advance");

    property p_flag_select;
        @(posedge clk) disable iff (!resetn)
        (ex_v && ex_sflag) |=> alias_uses_user_sp == $past(alu_new_stack_sel);
    endproperty
    a_flag_select: assert property (p_flag_select) else $error("stack select wrong");
endmodule

// File: instr_stream.sv
// instruction stream model presenting decode attributes to the control block
`timescale 1ns/1ps
`include "pipe_ctrl_defs.svh"
module instr_stream (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction kind from bench, random operands, branch target
    input wire logic [2:0] op,
    input wire logic [31:0] rnd,
    input wire logic [31:0] tgt,
    input wire logic decode_stall,
    // decode attributes
    output logic dec_valid,
    output logic [`REG_W-1:0] dec_src_a,
    output logic [`REG_W-1:0] dec_src_b,
    output logic dec_uses_src_a,
    output logic dec_uses_src_b,
    output logic dec_two_reg_format,
    output logic dec_writes_stack_sel,
    output logic dec_is_load,
    output logic [`REG_W-1:0] dec_dest,
    output pipe_ctrl_pkg::branch_kind_e dec_branch,
    output logic [31:0] dec_target
);
    logic [2:0] cur;
    logic [3:0] r;
    logic [3:0] ld_dest;
    logic was_load;
    // copy of the instruction shown last cycle, replayed while decode_stall is high
    logic [2:0] prev_op;
    logic [3:0] prev_r;
    logic [3:0] prev_ld_dest;
    logic prev_was_load;
    logic [2:0] show_op;
    logic [3:0] show_r;
    logic [3:0] show_ld_dest;
    logic show_was_load;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= 3'h0;
            r <= 4'h0;
            ld_dest <= 4'h0;
            was_load <= 1'b0;
            prev_op <= 3'h0;
            prev_r <= 4'h0;
            prev_ld_dest <= 4'h0;
            prev_was_load <= 1'b0;
        end else if (!decode_stall) begin
            // the interlock shows a cycle late, so the stalled instruction is replayed then
            prev_op <= cur;
            prev_r <= r;
            prev_ld_dest <= ld_dest;
            prev_was_load <= was_load;
            was_load <= (cur == 3'h6);
            ld_dest <= r;
            cur <= (cur == 3'h5) ? 3'h0 : op;
            r <= 4'(rnd[7:0] % 8'h0f);
        end
    end
    assign show_op = decode_stall ? prev_op : cur;
    assign show_r = decode_stall ? prev_r : r;
    assign show_ld_dest = decode_stall ? prev_ld_dest : ld_dest;
    assign show_was_load = decode_stall ? prev_was_load : was_load;
    assign dec_valid = 1'b1;
    assign dec_src_a = show_was_load ? show_ld_dest
        : ((show_op == 3'h2) ? `ALIAS_REG_NUM : show_r);
    assign dec_src_b = show_r;
    assign dec_uses_src_a = 1'b1;
    assign dec_uses_src_b = (show_op == 3'h3);
    assign dec_two_reg_format = (show_op == 3'h3);
    assign dec_writes_stack_sel = (show_op == 3'h1);
    assign dec_is_load = (show_op == 3'h6);
    assign dec_dest = show_r;
    assign dec_branch = (show_op == 3'h4) ? pipe_ctrl_pkg::br_plain :
        ((show_op == 3'h5) ? pipe_ctrl_pkg::br_delayed : pipe_ctrl_pkg::br_none);
    assign dec_target = tgt;
endmodule

// File: delayed_branch_pipeline_control_tb.sv
// self-checking bench for the pipeline control block
`timescale 1ns/1ps
`include "pipe_ctrl_defs.svh"
module delayed_branch_pipeline_control_tb;
    logic clk = 1'b0, resetn = 1'b0, mark = 1'b0, last_sel = 1'b0;
    logic alu_branch_cond = 1'b0, alu_new_stack_sel = 1'b0, exception_trap_request = 1'b0;
    logic [2:0] op = 3'h0;
    logic [31:0] rnd = 32'ha714, tgt = 32'h8000_0000, pc0;
    logic [3:0] dec_src_a, dec_src_b, dec_dest;
    logic dec_valid, dec_uses_src_a, dec_uses_src_b, dec_two_reg_format;
    logic dec_writes_stack_sel, dec_is_load, fetch_hold, decode_stall, cancel_follower;
    logic decode_stage_valid, alu_stage_valid, memory_access_stage_valid;
    logic register_writeback_stage_valid, stack_sel, alias_uses_user_sp, exception_trap_accept;
    pipe_ctrl_pkg::branch_kind_e dec_branch;
    logic [31:0] dec_target, fetch_pc;
    logic [5:0] seen = 6'h0;
    logic [5:0] notes[$];
    int miscompares = 0, total_checks = 0;
    instr_stream src_u (.clk, .resetn, .op, .rnd, .tgt, .decode_stall, .dec_valid, .dec_src_a,
        .dec_src_b, .dec_uses_src_a, .dec_uses_src_b, .dec_two_reg_format,
        .dec_writes_stack_sel, .dec_is_load, .dec_dest, .dec_branch, .dec_target);
    delayed_branch_pipeline_control dut_u (.clk, .resetn, .dec_valid, .dec_src_a, .dec_src_b,
        .dec_uses_src_a, .dec_uses_src_b, .dec_two_reg_format, .dec_writes_stack_sel,
        .dec_is_load, .dec_dest, .dec_branch, .dec_target, .alu_branch_cond,
        .alu_new_stack_sel, .exception_trap_request, .fetch_pc, .fetch_hold,
        .decode_stage_valid, .alu_stage_valid, .memory_access_stage_valid,
        .register_writeback_stage_valid, .decode_stall, .cancel_follower, .stack_sel,
        .alias_uses_user_sp, .exception_trap_accept);
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one instruction pair, then a drain of plain ops; flags seen are noted per window
    task automatic run(input logic [2:0] a, b, input logic c, s, x, input logic [3:0] e);
        rnd <= xs(rnd);
        op <= a;
        alu_branch_cond <= c;
        alu_new_stack_sel <= s;
        tgt <= {1'b1, rnd[30:1], 1'b0};
        @(posedge clk);
        op <= b;
        exception_trap_request <= x;
        @(posedge clk);
        op <= 3'h0;
        @(posedge clk);
        exception_trap_request <= 1'b0;
        repeat (6) @(posedge clk);
        if (a == 3'h1)
            last_sel = s;
        notes.push_back({e, last_sel, last_sel});
        mark <= 1'b1;
        @(posedge clk);
        mark <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (mark) begin
            check("window flags", {26'h0, notes.pop_front()},
                {26'h0, seen[5:2], stack_sel, alias_uses_user_sp});
            check("pipe full", 32'h0000_000f, {27'h0, fetch_hold, decode_stage_valid,
                alu_stage_valid, memory_access_stage_valid, register_writeback_stage_valid});
            seen <= 6'h0;
        end else if (resetn)
            seen <= seen | {decode_stall & fetch_hold, cancel_follower, exception_trap_accept,
                fetch_pc === tgt, 2'b00};
    end
    initial begin
        repeat (8) @(posedge clk);
        check("reset outputs", 32'h0,
            fetch_pc | {decode_stall, cancel_follower, fetch_hold, exception_trap_accept,
            stack_sel, decode_stage_valid, alu_stage_valid, memory_access_stage_valid,
            register_writeback_stage_valid});
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 pc0 = fetch_pc;
        @(posedge clk);
        #1 check("fetch step", pc0 + `PC_STEP, fetch_pc);
        @(posedge clk);
        run(3'h1, 3'h2, 1'b0, 1'b1, 1'b0, 4'b1000);
        run(3'h1, 3'h3, 1'b0, 1'b0, 1'b0, 4'b1000);
        run(3'h1, 3'h0, 1'b0, rnd[3], 1'b0, 4'b0000);
        run(3'h6, 3'h0, 1'b0, 1'b0, 1'b0, 4'b1000);
        run(3'h4, 3'h0, 1'b1, 1'b0, 1'b0, 4'b0101);
        run(3'h4, 3'h0, 1'b0, 1'b0, 1'b0, 4'b0000);
        run(3'h5, 3'h0, 1'b1, 1'b0, 1'b1, 4'b0001);
        run(3'h5, 3'h0, 1'b0, 1'b0, 1'b1, 4'b0000);
        run(3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 4'b0010);
        final_report();
    end
    initial begin
        #20us;
        miscompares++;
        final_report();
    end
endmodule
